//--- hdl/refsel_pkg.sv
// Package: register map, field layout and reset values for the reference select control
package refsel_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] LEVEL_SELECT_OFS = 8'h00;
    localparam logic [7:0] FORCE_ENABLE_OFS = 8'h01;
    localparam logic [7:0] LEVEL_SELECT_RST = 8'h00;
    localparam logic [7:0] FORCE_ENABLE_RST = 8'h00;
    localparam int CONV_SEL_LSB = 4;
    localparam int CONV_SEL_MSB = 6;
    localparam int COMP_SEL_LSB = 0;
    localparam int COMP_SEL_MSB = 2;
    localparam int CONV_FORCE_BIT = 1;
    localparam int COMP_FORCE_BIT = 0;
    localparam logic [7:0] LEVEL_SELECT_MASK = 8'h77;
    localparam logic [7:0] FORCE_ENABLE_MASK = 8'h03;
    // Level codes shared by both consumers
    localparam logic [2:0] LVL_0V55 = 3'h0;
    localparam logic [2:0] LVL_1V1 = 3'h1;
    localparam logic [2:0] LVL_2V5 = 3'h2;
    localparam logic [2:0] LVL_4V3 = 3'h3;
    localparam logic [2:0] LVL_1V5 = 3'h4;
    localparam logic [2:0] LVL_SUPPLY = 3'h7;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic buffer_on;
        logic bandgap_on;
        logic [2:0] level;
        logic level_valid;
    } ref_ctrl_t;
endpackage

//--- hdl/ref_channel.sv
// One reference consumer: enable combine and level code decode
`timescale 1ns/1ps
module ref_channel
    import refsel_pkg::*;
#(
    parameter bit SUPPLY_ALLOWED = 1'b0
) (
    input wire logic [2:0] level_sel, // Programmed level code
    input wire logic force_on, // Software force-enable bit
    input wire logic request, // Consumer peripheral request
    output ref_ctrl_t ctrl // Buffer enable and level to analog
);
    logic code_ok;

    always_comb begin
        unique case (level_sel)
            LVL_0V55, LVL_1V1, LVL_2V5, LVL_4V3, LVL_1V5: code_ok = 1'b1;
            LVL_SUPPLY: code_ok = SUPPLY_ALLOWED;
            default: code_ok = 1'b0;
        endcase
    end

    always_comb begin
        ctrl.buffer_on = force_on | request;
        ctrl.bandgap_on = force_on | request;
        ctrl.level = level_sel;
        ctrl.level_valid = code_ok;
    end
endmodule

//--- hdl/reference_select_enable_control.sv
// Reference level select and buffer enable control with register port
`timescale 1ns/1ps
// Function
// - Converter level field bits 6:4, codes 0..4 map to levels, rest reserved.
// - Comparator level field bits 2:0, same codes, 7 selects analog supply.
// - A requesting peripheral turns on its buffer and the bandgap automatically.
// - Converter force bit 1 keeps converter reference on without request.
// - Comparator force bit 0 keeps comparator DAC reference on regardless.
// - With force cleared, enable follows the peripheral request only.
module reference_select_enable_control
    import refsel_pkg::*;
(
    input wire logic clk, // 20 MHz bus clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [ADDR_W-1:0] addr, // Register address
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [DATA_W-1:0] rdata, // Read data, cycle after rd
    input wire logic converter_request, // Converter wants its reference
    input wire logic comparator_request, // Comparator wants its reference
    output ref_ctrl_t converter_ref, // Converter buffer control
    output ref_ctrl_t comparator_ref, // Comparator buffer control
    output logic bandgap_on // Shared bandgap enable
);
    reg_req_t req;
    logic [7:0] level_q, level_d;
    logic [7:0] force_q, force_d;
    logic [7:0] rdata_q, rdata_d;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    always_comb begin
        level_d = level_q;
        force_d = force_q;
        if (req.wr && req.addr == LEVEL_SELECT_OFS) begin
            level_d = req.wdata & LEVEL_SELECT_MASK;
        end
        if (req.wr && req.addr == FORCE_ENABLE_OFS) begin
            force_d = req.wdata & FORCE_ENABLE_MASK;
        end
    end

    // Unmapped addresses read as zero; reserved bits read as zero
    always_comb begin
        rdata_d = 8'h00;
        if (req.rd) begin
            if (req.addr == LEVEL_SELECT_OFS) begin
                rdata_d = level_q;
            end else if (req.addr == FORCE_ENABLE_OFS) begin
                rdata_d = force_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= LEVEL_SELECT_RST;
            force_q <= FORCE_ENABLE_RST;
            rdata_q <= 8'h00;
        end else begin
            level_q <= level_d;
            force_q <= force_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // Request comes from logic on this clock, so no synchroniser; enable is
    // combinational so the buffer starts the same cycle the consumer asks.
    // Index 0 is the converter, index 1 the comparator
    logic [2:0] chan_sel [2];
    logic [1:0] chan_force;
    logic [1:0] chan_req;
    ref_ctrl_t chan_ref [2];

    assign chan_sel[0] = level_q[CONV_SEL_MSB:CONV_SEL_LSB];
    assign chan_sel[1] = level_q[COMP_SEL_MSB:COMP_SEL_LSB];
    assign chan_force = {force_q[COMP_FORCE_BIT], force_q[CONV_FORCE_BIT]};
    assign chan_req = {comparator_request, converter_request};

    // Only the comparator may take the analog supply as its level
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        ref_channel #(.SUPPLY_ALLOWED((ch == 1) ? 1'b1 : 1'b0)) u_chan (
            .level_sel(chan_sel[ch]),
            .force_on(chan_force[ch]),
            .request(chan_req[ch]),
            .ctrl(chan_ref[ch])
        );
    end

    assign converter_ref = chan_ref[0];
    assign comparator_ref = chan_ref[1];

    assign bandgap_on = converter_ref.bandgap_on | comparator_ref.bandgap_on;

    property p_conv_enable;
        @(posedge clk) disable iff (!rst_n)
        converter_ref.buffer_on == (force_q[CONV_FORCE_BIT] | converter_request);
    endproperty
    a_conv_enable: assert property (p_conv_enable) else $error("converter enable wrong");

    property p_comp_enable;
        @(posedge clk) disable iff (!rst_n)
        comparator_ref.buffer_on == (force_q[COMP_FORCE_BIT] | comparator_request);
    endproperty
    a_comp_enable: assert property (p_comp_enable) else $error("comparator enable wrong");

    property p_auto_follow;
        @(posedge clk) disable iff (!rst_n)
        (!force_q[CONV_FORCE_BIT] && !converter_request) |-> !converter_ref.buffer_on;
    endproperty
    a_auto_follow: assert property (p_auto_follow) else $error("converter on unrequested");

    property p_bandgap;
        @(posedge clk) disable iff (!rst_n)
        (converter_request || comparator_request) |-> bandgap_on;
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap off on request");

    property p_force_write;
        @(posedge clk) disable iff (!rst_n)
        (wr && addr == FORCE_ENABLE_OFS && wdata[CONV_FORCE_BIT])
            |=> converter_ref.buffer_on;
    endproperty
    a_force_write: assert property (p_force_write) else $error("force write ignored");

    property p_conv_valid;
        @(posedge clk) disable iff (!rst_n)
        (level_q[CONV_SEL_MSB:CONV_SEL_LSB] > LVL_1V5) |-> !converter_ref.level_valid;
    endproperty
    a_conv_valid: assert property (p_conv_valid) else $error("reserved converter code valid");

    property p_comp_supply;
        @(posedge clk) disable iff (!rst_n)
        (level_q[COMP_SEL_MSB:COMP_SEL_LSB] == LVL_SUPPLY) |-> comparator_ref.level_valid;
    endproperty
    a_comp_supply: assert property (p_comp_supply) else $error("supply code not valid");

    property p_level_read;
        @(posedge clk) disable iff (!rst_n)
        (rd && addr == LEVEL_SELECT_OFS) |=> rdata == $past(level_q);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level readback wrong");

    property p_comp_follow;
        @(posedge clk) disable iff (!rst_n)
        (!force_q[COMP_FORCE_BIT] && !comparator_request) |-> !comparator_ref.buffer_on;
    endproperty
    a_comp_follow: assert property (p_comp_follow)
        else $error("comparator on unrequested");

    property p_conv_request_on;
        @(posedge clk) disable iff (!rst_n)
        converter_request |-> (converter_ref.buffer_on && bandgap_on);
    endproperty
    a_conv_request_on: assert property (p_conv_request_on)
        else $error("converter request not served");

    property p_comp_request_on;
        @(posedge clk) disable iff (!rst_n)
        comparator_request |-> (comparator_ref.buffer_on && bandgap_on);
    endproperty
    a_comp_request_on: assert property (p_comp_request_on)
        else $error("comparator request not served");

    property p_bandgap_idle;
        @(posedge clk) disable iff (!rst_n)
        (!force_q[CONV_FORCE_BIT] && !force_q[COMP_FORCE_BIT]
            && !converter_request && !comparator_request) |-> !bandgap_on;
    endproperty
    a_bandgap_idle: assert property (p_bandgap_idle)
        else $error("bandgap on while idle");

    property p_comp_force_write;
        @(posedge clk) disable iff (!rst_n)
        (wr && addr == FORCE_ENABLE_OFS && wdata[COMP_FORCE_BIT])
            |=> comparator_ref.buffer_on;
    endproperty
    a_comp_force_write: assert property (p_comp_force_write)
        else $error("comparator force write ignored");

    property p_conv_level_write;
        @(posedge clk) disable iff (!rst_n)
        (wr && addr == LEVEL_SELECT_OFS)
            |=> converter_ref.level == $past(wdata[CONV_SEL_MSB:CONV_SEL_LSB]);
    endproperty
    a_conv_level_write: assert property (p_conv_level_write)
        else $error("converter level write lost");

    property p_comp_level_write;
        @(posedge clk) disable iff (!rst_n)
        (wr && addr == LEVEL_SELECT_OFS)
            |=> comparator_ref.level == $past(wdata[COMP_SEL_MSB:COMP_SEL_LSB]);
    endproperty
    a_comp_level_write: assert property (p_comp_level_write)
        else $error("comparator level write lost");

    property p_force_read;
        @(posedge clk) disable iff (!rst_n)
        (rd && addr == FORCE_ENABLE_OFS) |=> rdata == $past(force_q);
    endproperty
    a_force_read: assert property (p_force_read)
        else $error("force readback wrong");

    property p_rdata_idle;
        @(posedge clk) disable iff (!rst_n)
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not cleared");

    property p_level_reserved;
        @(posedge clk) disable iff (!rst_n)
        (level_q & ~LEVEL_SELECT_MASK) == 8'h00;
    endproperty
    a_level_reserved: assert property (p_level_reserved)
        else $error("reserved level bit stored");

    property p_force_reserved;
        @(posedge clk) disable iff (!rst_n)
        (force_q & ~FORCE_ENABLE_MASK) == 8'h00;
    endproperty
    a_force_reserved: assert property (p_force_reserved)
        else $error("reserved force bit stored");

    property p_comp_reserved;
        @(posedge clk) disable iff (!rst_n)
        (level_q[COMP_SEL_MSB:COMP_SEL_LSB] > LVL_1V5
            && level_q[COMP_SEL_MSB:COMP_SEL_LSB] != LVL_SUPPLY) |-> !comparator_ref.level_valid;
    endproperty
    a_comp_reserved: assert property (p_comp_reserved)
        else $error("reserved comparator code valid");

    property p_conv_valid_code;
        @(posedge clk) disable iff (!rst_n)
        (level_q[CONV_SEL_MSB:CONV_SEL_LSB] <= LVL_1V5) |-> converter_ref.level_valid;
    endproperty
    a_conv_valid_code: assert property (p_conv_valid_code)
        else $error("converter level code refused");

    property p_comp_valid_code;
        @(posedge clk) disable iff (!rst_n)
        (level_q[COMP_SEL_MSB:COMP_SEL_LSB] <= LVL_1V5) |-> comparator_ref.level_valid;
    endproperty
    a_comp_valid_code: assert property (p_comp_valid_code)
        else $error("comparator level code refused");
endmodule

//--- bench/ref_consumer_model.sv
// Consumer peripheral model raising a reference request
`timescale 1ns/1ps
module ref_consumer_model #(parameter int LAG = 0) (
    input wire logic clk, // Bus clock
    input wire logic rst_n, // Reset, active low
    input wire logic enable, // Peripheral enabled
    output logic request // Reference wanted
);
    logic [3:0] lag_q;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) lag_q <= 4'h0;
        else lag_q <= {lag_q[2:0], enable};
    // A slow part asks late; levels are set before it is enabled
    assign request = lag_q[LAG];
endmodule

//--- bench/testbench.sv
// Self-checking bench for the reference select control
`timescale 1ns/1ps
module testbench;
    import refsel_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, conv_en = 1'b0, comp_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lvl, bad;
    logic conv_req, comp_req, bandgap_on, con, cmp;
    ref_ctrl_t conv_ref, comp_ref;
    logic [31:0] seed = 32'h0000002B;
    int err_count = 0, n_tests = 0, cycles = 0;
    always #25 clk = ~clk;
    reference_select_enable_control i_dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .converter_request(conv_req), .comparator_request(comp_req),
        .converter_ref(conv_ref), .comparator_ref(comp_ref), .bandgap_on);
    ref_consumer_model #(.LAG(0)) i_conv (.clk, .rst_n, .enable(conv_en), .request(conv_req));
    ref_consumer_model #(.LAG(2)) i_comp (.clk, .rst_n, .enable(comp_en), .request(comp_req));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] exp_ref(input logic on, input logic [2:0] c, input logic sup);
        return {2'b00, on, on, c, (c <= 3'h4) || (sup && c == 3'h7)};
    endfunction
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata} <= {a, d};
        {wr, rd} <= {w, !w};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        if (!w) begin
            #1 check("rdata", d, rdata);
            @(posedge clk);
            #1 check("rdata_idle", 8'h00, rdata);
        end
    endtask
    always @(posedge clk)
        if (++cycles == 3000) begin
            err_count++;
            finish_test();
        end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        access(1'b0, LEVEL_SELECT_OFS, LEVEL_SELECT_RST);
        access(1'b0, FORCE_ENABLE_OFS, FORCE_ENABLE_RST);
        for (int i = 0; i < 40; i++) begin
            seed = xorshift(seed);
            lvl = (i < 8) ? {1'b1, i[2:0], 1'b1, 3'(7 - i)} : seed[7:0];
            bad = seed[23:16] | 8'h02;
            con = seed[9] | seed[17];
            cmp = seed[8] | seed[16];
            @(posedge clk);
            {conv_en, comp_en} <= 2'b00;
            repeat (4) @(posedge clk);
            access(1'b1, LEVEL_SELECT_OFS, lvl);
            access(1'b1, FORCE_ENABLE_OFS, seed[15:8]);
            access(1'b1, bad, seed[31:24]);
            access(1'b0, LEVEL_SELECT_OFS, lvl & LEVEL_SELECT_MASK);
            access(1'b0, FORCE_ENABLE_OFS, seed[15:8] & FORCE_ENABLE_MASK);
            access(1'b0, bad, 8'h00);
            @(posedge clk);
            {conv_en, comp_en} <= seed[17:16];
            repeat (4) @(posedge clk);
            #1 check("conv_ref", exp_ref(con, lvl[6:4], 1'b0), 8'(conv_ref));
            check("comp_ref", exp_ref(cmp, lvl[2:0], 1'b1), 8'(comp_ref));
            check("bandgap_on", {7'h00, con | cmp}, {7'h00, bandgap_on});
        end
        // Mid-run reset must bring both registers and the enables back to rest
        @(posedge clk);
        {conv_en, comp_en} <= 2'b00;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        access(1'b0, LEVEL_SELECT_OFS, LEVEL_SELECT_RST);
        access(1'b0, FORCE_ENABLE_OFS, FORCE_ENABLE_RST);
        #1 check("conv_ref", exp_ref(1'b0, LVL_0V55, 1'b0), 8'(conv_ref));
        check("comp_ref", exp_ref(1'b0, LVL_0V55, 1'b1), 8'(comp_ref));
        check("bandgap_on", 8'h00, {7'h00, bandgap_on});
        finish_test();
    end
endmodule
